// ===== usart_master_spi.sv
// Serial unit in master-only SPI mode with an APB register slave
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module usart_master_spi
    import mspi_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core interrupt side
    input  wire logic        globalIrqEnable,
    input  wire logic        txCompleteIrqAck,
    output logic             rxCompleteIrq,
    output logic             txCompleteIrq,
    output logic             txBufferEmptyIrq,
    // Serial pins
    input  wire logic        serialInPin,
    output logic             serialOutPin,
    output logic             serialOutOverride,
    output logic             serialInOverride,
    output logic             transferClockPin,
    output logic             transferClockOverride
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]            control_r;
    logic [7:0]            config_r;
    logic [BAUD_WIDTH-1:0] baud_r;
    logic                  txEnActive_r;
    logic                  txComplete_r;
    logic [7:0]            txBuf_r;
    logic                  txBufFull_r;
    logic [7:0]            txShift_r;
    logic [7:0]            rxShift_r;
    engine_state_t         state_r;
    logic [BAUD_WIDTH-1:0] halfCnt_r;
    logic [4:0]            edgeIdx_r;
    logic                  sck_r;
    logic                  mosi_r;
    logic                  inMeta_r;
    logic                  inSync_r;
    logic                  setupPhase;
    logic                  accessDone;
    logic                  wrDone;
    logic                  rdDone;
    logic                  spiMode;
    logic                  lsbFirst;
    logic                  phase;
    logic                  halfTick;
    logic                  lastEdge;
    logic                  loadShift;
    logic                  frameDone;
    logic                  sampleEdge;
    logic                  driveEdge;
    logic                  rxPush;
    logic [7:0]            rxWord;
    logic                  rxNotEmpty;
    logic [7:0]            rxHead;
    logic                  rxPop;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] regSel(input logic [7:0] addr);
        regSel = addr;
    endfunction

    // Position of frame bit n inside a byte, for either bit order
    function automatic logic [2:0] bitPos(input logic [2:0] n,
                                          input logic       lsb);
        bitPos = lsb ? n : 3'(3'h7 - n);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == OFF_DATA) || (addr == OFF_STATUS) ||
                 (addr == OFF_CONTROL) || (addr == OFF_CONFIG) ||
                 (addr == OFF_BAUD);
    endfunction

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone     = accessDone && pwrite && !pslverr;
    assign rdDone     = accessDone && !pwrite && !pslverr;

    // One wait-free access phase; read data captured in setup
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !mapped(paddr);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (clkEn && setupPhase) begin
            prdata <= '0;
            unique case (regSel(paddr))
                OFF_DATA:    prdata[7:0] <= rxHead;
                // Error flags stay zero in this mode
                OFF_STATUS:  prdata[7:0] <= {rxNotEmpty, txComplete_r,
                                             !txBufFull_r, 5'h00};
                OFF_CONTROL: prdata[7:0] <= control_r;
                OFF_CONFIG:  prdata[7:0] <= config_r & CONFIG_RW_MASK;
                OFF_BAUD:    prdata[BAUD_WIDTH-1:0] <= baud_r;
                default:     prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control, configuration and baud registers
    // ------------------------------------------------------------------
    // Only defined bits are stored; no collision or double-speed bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            control_r <= CONTROL_RESET;
        end else if (clkEn && wrDone && paddr == OFF_CONTROL) begin
            control_r <= pwdata[7:0] & 8'hF8;
        end
    end

    // One write carries mode, order, phase and polarity together
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            config_r <= CONFIG_RESET;
        end else if (clkEn && wrDone && paddr == OFF_CONFIG) begin
            config_r <= pwdata[7:0] & CONFIG_RW_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            baud_r <= BAUD_RESET;
        end else if (clkEn && wrDone && paddr == OFF_BAUD) begin
            baud_r <= pwdata[BAUD_WIDTH-1:0];
        end
    end

    // Only the master SPI encoding runs the engine here
    assign spiMode  = {config_r[CFG_MODE_HI], config_r[CFG_MODE_LO]} ==
                      MODE_MASTER_SPI;
    assign lsbFirst = config_r[CFG_LSB_FIRST];
    assign phase    = config_r[CFG_PHASE];

    // ------------------------------------------------------------------
    // Transmitter enable with deferred disable
    // ------------------------------------------------------------------
    // A cleared enable waits until shifter and buffer drain
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txEnActive_r <= 1'b0;
        end else if (clkEn) begin
            if (control_r[CTL_TRANSMIT_EN]) begin
                txEnActive_r <= 1'b1;
            end else if (state_r == ENG_IDLE && !txBufFull_r) begin
                txEnActive_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit holding register
    // ------------------------------------------------------------------
    // Writes into a full holding register are ignored, nothing flags it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txBuf_r     <= '0;
            txBufFull_r <= 1'b0;
        end else if (clkEn) begin
            if (wrDone && paddr == OFF_DATA && !txBufFull_r) begin
                txBuf_r     <= pwdata[7:0];
                txBufFull_r <= 1'b1;
            end else if (loadShift) begin
                txBufFull_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit-complete flag
    // ------------------------------------------------------------------
    // Hardware set wins over service or software clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txComplete_r <= 1'b0;
        end else if (clkEn) begin
            if (frameDone && !txBufFull_r) begin
                txComplete_r <= 1'b1;
            end else if (txCompleteIrqAck) begin
                txComplete_r <= 1'b0;
            end else if (wrDone && paddr == OFF_STATUS &&
                         pwdata[STS_TX_COMPLETE]) begin
                txComplete_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shift engine and clock generation
    // ------------------------------------------------------------------
    // The transmitter owns the clock, so without it nothing moves
    assign loadShift  = clkEn && state_r == ENG_IDLE && txBufFull_r &&
                        txEnActive_r && spiMode;
    // Half period is divisor plus one system cycles
    assign halfTick   = state_r == ENG_SHIFT && halfCnt_r == baud_r;
    assign lastEdge   = edgeIdx_r == 5'(FRAME_EDGES - 1);
    assign frameDone  = clkEn && halfTick && lastEdge;
    // Leading edges are even; phase picks the sampling edge
    assign sampleEdge = halfTick && (edgeIdx_r[0] == phase);
    assign driveEdge  = halfTick && (edgeIdx_r[0] != phase) && !lastEdge;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r   <= ENG_IDLE;
            halfCnt_r <= '0;
            edgeIdx_r <= '0;
            txShift_r <= '0;
        end else if (clkEn) begin
            unique case (state_r)
                ENG_IDLE: begin
                    halfCnt_r <= '0;
                    edgeIdx_r <= '0;
                    if (loadShift) begin
                        txShift_r <= txBuf_r;
                        state_r   <= ENG_SHIFT;
                    end
                end
                ENG_SHIFT: begin
                    if (halfTick) begin
                        halfCnt_r <= '0;
                        edgeIdx_r <= 5'(edgeIdx_r + 1'b1);
                        if (lastEdge) begin
                            state_r <= ENG_IDLE;
                        end
                    end else begin
                        halfCnt_r <= BAUD_WIDTH'(halfCnt_r + 1'b1);
                    end
                end
            endcase
        end
    end

    // Clock idles at the polarity level and toggles each half period
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sck_r <= 1'b0;
        end else if (clkEn) begin
            if (state_r == ENG_IDLE) begin
                sck_r <= config_r[CFG_POLARITY];
            end else if (halfTick) begin
                sck_r <= !sck_r;
            end
        end
    end

    // Data line idles high; first bit leads the clock in phase 0
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mosi_r <= 1'b1;
        end else if (clkEn) begin
            if (loadShift && !phase) begin
                mosi_r <= txBuf_r[bitPos(3'h0, lsbFirst)];
            end else if (state_r == ENG_SHIFT && phase && halfTick &&
                         !edgeIdx_r[0]) begin
                mosi_r <= txShift_r[bitPos(edgeIdx_r[3:1], lsbFirst)];
            end else if (driveEdge) begin
                mosi_r <= txShift_r[bitPos(3'(edgeIdx_r[3:1] + 1'b1),
                                           lsbFirst)];
            end else if (state_r == ENG_IDLE && !loadShift) begin
                mosi_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    // The pin is asynchronous to the system clock
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            inMeta_r <= 1'b1;
            inSync_r <= 1'b1;
        end else if (clkEn) begin
            inMeta_r <= serialInPin;
            inSync_r <= inMeta_r;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxShift_r <= '0;
        end else if (clkEn && sampleEdge) begin
            rxShift_r[bitPos(edgeIdx_r[3:1], lsbFirst)] <= inSync_r;
        end
    end

    // The final sample is merged so the byte lands with the last edge
    always_comb begin
        rxWord = rxShift_r;
        if (sampleEdge) begin
            rxWord[bitPos(edgeIdx_r[3:1], lsbFirst)] = inSync_r;
        end
    end

    assign rxPush = frameDone && control_r[CTL_RECEIVER_EN];
    assign rxPop  = rdDone && paddr == OFF_DATA;

    // Two entries: the extra level beyond the shifter
    rx_buffer #(
        .WIDTH (8),
        .DEPTH (RX_DEPTH)
    ) u_rx_buffer (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .flush    (!control_r[CTL_RECEIVER_EN]),
        .push     (rxPush),
        .wrData   (rxWord),
        .pop      (rxPop),
        .notEmpty (rxNotEmpty),
        .full     (),
        .headData (rxHead)
    );

    // ------------------------------------------------------------------
    // Interrupt requests and pin outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxCompleteIrq    <= 1'b0;
            txCompleteIrq    <= 1'b0;
            txBufferEmptyIrq <= 1'b0;
        end else if (clkEn) begin
            rxCompleteIrq    <= control_r[CTL_RX_IRQ_EN] &&
                                globalIrqEnable && rxNotEmpty;
            txCompleteIrq    <= control_r[CTL_TXC_IRQ_EN] &&
                                globalIrqEnable && txComplete_r;
            txBufferEmptyIrq <= control_r[CTL_TXE_IRQ_EN] &&
                                globalIrqEnable && !txBufFull_r;
        end
    end

    // No select pin: slaves are chosen outside this block
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serialOutPin          <= 1'b1;
            serialOutOverride     <= 1'b0;
            serialInOverride      <= 1'b0;
            transferClockPin      <= 1'b0;
            transferClockOverride <= 1'b0;
        end else if (clkEn) begin
            serialOutPin          <= mosi_r;
            serialOutOverride     <= txEnActive_r;
            serialInOverride      <= control_r[CTL_RECEIVER_EN];
            transferClockPin      <= sck_r;
            transferClockOverride <= txEnActive_r;
        end
    end

endmodule

// ===== mspi_pkg.sv
// Constants shared by the master-SPI serial unit and its receive buffer
package mspi_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the APB slave
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_DATA    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_CONFIG  = 8'h0C;
    localparam logic [7:0] OFF_BAUD    = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int STS_RX_COMPLETE   = 7;
    localparam int STS_TX_COMPLETE   = 6;
    localparam int STS_TX_BUF_EMPTY  = 5;
    localparam int CTL_RX_IRQ_EN     = 7;
    localparam int CTL_TXC_IRQ_EN    = 6;
    localparam int CTL_TXE_IRQ_EN    = 5;
    localparam int CTL_RECEIVER_EN   = 4;
    localparam int CTL_TRANSMIT_EN   = 3;
    localparam int CFG_MODE_HI       = 7;
    localparam int CFG_MODE_LO       = 6;
    localparam int CFG_LSB_FIRST     = 2;
    localparam int CFG_PHASE         = 1;
    localparam int CFG_POLARITY      = 0;

    // ------------------------------------------------------------------
    // Reset values, encodings and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  CONFIG_RESET   = 8'h06;
    localparam logic [7:0]  CONFIG_RW_MASK = 8'hC7;
    localparam logic [11:0] BAUD_RESET     = 12'h000;
    localparam logic [1:0]  MODE_ASYNC     = 2'h0;
    localparam logic [1:0]  MODE_SYNC      = 2'h1;
    localparam logic [1:0]  MODE_RESERVED  = 2'h2;
    localparam logic [1:0]  MODE_MASTER_SPI = 2'h3;
    localparam int          FRAME_BITS     = 8;
    localparam int          FRAME_EDGES    = 2 * FRAME_BITS;
    localparam int          BAUD_WIDTH     = 12;
    localparam int          RX_DEPTH       = 2;

    typedef enum logic [0:0] {ENG_IDLE, ENG_SHIFT} engine_state_t;

endpackage

// ===== rx_buffer.sv
// Small receive buffer whose head word comes out of a register
`timescale 1ns/1ps
module rx_buffer
    import mspi_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = RX_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clkEn,
    // Control
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             pop,
    // Status
    output logic                  notEmpty,
    output logic                  full,
    output logic      [WIDTH-1:0] headData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      count_r;
    logic             doPush;
    logic             doPop;
    logic [PW-1:0]    headIdx;

    // A push into a full buffer is dropped so older bytes survive
    assign doPush  = push && (count_r != DEPTH_C);
    assign doPop   = pop && (count_r != '0);
    assign headIdx = doPop ? PW'(rdPtr_r + 1'b1) : rdPtr_r;

    always_ff @(posedge clk_sys) begin
        if (clkEn && doPush) begin
            mem[wrPtr_r] <= wrData;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (clkEn) begin
            if (flush) begin
                wrPtr_r <= '0;
                rdPtr_r <= '0;
                count_r <= '0;
            end else begin
                if (doPush) begin
                    wrPtr_r <= PW'(wrPtr_r + 1'b1);
                end
                if (doPop) begin
                    rdPtr_r <= PW'(rdPtr_r + 1'b1);
                end
                count_r <= count_r + (PW + 1)'(doPush) - (PW + 1)'(doPop);
            end
        end
    end

    // Head register follows the entry at the new read pointer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            headData <= '0;
        end else if (clkEn) begin
            if (doPush && (headIdx == wrPtr_r)) begin
                headData <= wrData;
            end else begin
                headData <= mem[headIdx];
            end
        end
    end

    assign notEmpty = (count_r != '0);
    assign full     = (count_r == DEPTH_C);

endmodule

// ===== mspi_properties.sv
// Checker of bus and interrupt timing for the master-SPI unit
`timescale 1ns/1ps
module mspi_checker (
    // Clock, reset and bus
    input wire logic clk_sys, resetn, psel, penable, pready, pslverr,
    // Interrupt side
    input wire logic globalIrqEnable, rxCompleteIrq,
    input wire logic txCompleteIrq, txBufferEmptyIrq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence setupS; psel && !penable; endsequence
    sequence globalOffS; !globalIrqEnable [*2]; endsequence
    AST_READY_AFTER_SETUP:
        assert property (setupS |=> pready) else $error("no ready");
    AST_READY_ONE_CYCLE:
        assert property (pready |=> !pready) else $error("long ready");
    AST_READY_HAS_SETUP:
        assert property (pready |-> $past(psel && !penable))
        else $error("stray ready");
    AST_SLVERR_IN_ACCESS:
        assert property (pslverr |-> pready) else $error("stray slverr");
    AST_RX_IRQ_GATED:
        assert property (rxCompleteIrq |-> $past(globalIrqEnable))
        else $error("rx irq while masked");
    AST_TXC_IRQ_GATED:
        assert property (txCompleteIrq |-> $past(globalIrqEnable))
        else $error("txc irq while masked");
    AST_TXE_IRQ_GATED:
        assert property (txBufferEmptyIrq |-> $past(globalIrqEnable))
        else $error("txe irq while masked");
    AST_IRQ_QUIET:
        assert property (globalOffS |->
            !(rxCompleteIrq || txCompleteIrq || txBufferEmptyIrq))
        else $error("irq with global flag low");
endmodule
bind usart_master_spi mspi_checker u_chk (.clk_sys, .resetn, .psel,
    .penable, .pready, .pslverr, .globalIrqEnable, .rxCompleteIrq,
    .txCompleteIrq, .txBufferEmptyIrq);

// ===== spi_slave_model.sv
// Far-side slave wired as a loopback of the master-out line
`timescale 1ns/1ps
module spi_slave_model (
    input  wire logic clk_sys,
    input  wire logic mosi,
    input  wire logic mosiEn,
    output logic      miso
);
    // Released line toggles so a stale value can never pass
    assign miso = mosiEn ? mosi : clk_sys;
endmodule

// ===== tb_usart_master_spi.sv
// Self-checking bench for the master-SPI serial unit
`timescale 1ns/1ps
module tb_usart_master_spi;
    import mspi_pkg::*;
    logic clk_sys, resetn, clkEn, psel, penable, pwrite, err, sckQ;
    logic globalIrqEnable, txCompleteIrqAck, serialInPin, pready, pslverr;
    logic rxIrq, txcIrq, txeIrq, sOut, sOutEn, sInEn, sck, sckEn;
    logic [7:0]  paddr, cfg, wireByte, b;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  sentQ[$], rxQ[$];
    int          fails, n_compared, bitCnt, seed, rnd;
    usart_master_spi u_dut (.clk_sys, .resetn, .clkEn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .globalIrqEnable, .txCompleteIrqAck, .rxCompleteIrq(rxIrq),
        .txCompleteIrq(txcIrq), .txBufferEmptyIrq(txeIrq), .serialInPin,
        .serialOutPin(sOut), .serialOutOverride(sOutEn),
        .serialInOverride(sInEn), .transferClockPin(sck),
        .transferClockOverride(sckEn));
    spi_slave_model u_slave (.clk_sys, .mosi(sOut), .mosiEn(sOutEn),
        .miso(serialInPin));
    initial begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("compared=%0d fails=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        n = 0;
        do begin @(posedge clk_sys); n++; end
        while (pready !== 1'b1 && n < 20);
        if (n == 20) begin fails++; finish_test; end
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask
    task waitSts(input int bitPos);
        int n;
        n = 0;
        do begin apb(0, OFF_STATUS, 0); n++; end
        while (rd[bitPos] !== 1'b1 && n < 500);
        if (n == 500) begin fails++; finish_test; end
    endtask
    task sendByte;
        rnd = $random(seed); b = rnd[7:0];
        waitSts(STS_TX_BUF_EMPTY);
        sentQ.push_back(b);
        apb(1, OFF_DATA, {24'h0, b});
    endtask
    // Reference of the wire: sample master-out on each sampling edge
    always @(posedge clk_sys) begin
        if (sckEn === 1'b1 && sck !== sckQ) begin
            if ((sck != cfg[CFG_POLARITY]) ^ cfg[CFG_PHASE]) begin
                wireByte = cfg[CFG_LSB_FIRST] ? {sOut, wireByte[7:1]}
                                              : {wireByte[6:0], sOut};
                bitCnt++;
            end
            if (bitCnt == FRAME_BITS) begin
                chk(wireByte, sentQ.pop_front());
                if (sInEn && rxQ.size() < RX_DEPTH)
                    rxQ.push_back(wireByte);
                bitCnt = 0;
            end
        end
        sckQ = sck;
    end
    initial begin
        seed = 81898; fails = 0; n_compared = 0; bitCnt = 0; sckQ = 0;
        cfg = CONFIG_RESET; resetn = 0; clkEn = 1; psel = 0; penable = 0;
        pwrite = 0; paddr = 0; pwdata = 0; globalIrqEnable = 0;
        txCompleteIrqAck = 0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1;
        apb(0, OFF_STATUS, 0); chk(rd, 32'h20);
        apb(0, OFF_CONFIG, 0); chk(rd, 32'h06);
        apb(0, 8'h14, 0); chk(err, 1'b1);
        apb(1, OFF_CONTROL, 32'h10);
        repeat (3) @(posedge clk_sys);
        chk({sInEn, sOutEn}, 2'b10);
        for (int m = 0; m < 8; m++) begin
            cfg = {MODE_MASTER_SPI, 3'h0, m[2:0]};
            apb(1, OFF_CONFIG, {24'h0, cfg});
            apb(1, OFF_CONTROL, 32'h18);
            repeat (3) @(posedge clk_sys);
            chk({sOutEn, sckEn}, 2'b11);
            apb(1, OFF_BAUD, 32'h5);
            // A new idle level on the clock pin is not a frame edge
            bitCnt = 0;
            repeat (3) sendByte;
            waitSts(STS_TX_COMPLETE);
            chk(rd, 32'hE0);
            repeat (2) begin
                apb(0, OFF_DATA, 0); chk(rd, {24'h0, rxQ.pop_front()});
            end
            if (m[0]) apb(1, OFF_STATUS, 32'h40);
            else begin
                txCompleteIrqAck <= 1; @(posedge clk_sys);
                txCompleteIrqAck <= 0;
            end
            apb(0, OFF_STATUS, 0); chk(rd, 32'h20);
        end
        sendByte;
        waitSts(STS_TX_COMPLETE);
        chk(rd, 32'hE0);
        apb(1, OFF_CONTROL, 32'h08); rxQ.delete();
        apb(0, OFF_STATUS, 0); chk(rd[7], 1'b0);
        apb(1, OFF_CONTROL, 32'hE8); globalIrqEnable <= 1;
        repeat (3) @(posedge clk_sys);
        chk({rxIrq, txcIrq, txeIrq}, 3'b011);
        globalIrqEnable <= 0;
        repeat (3) @(posedge clk_sys);
        chk({rxIrq, txcIrq, txeIrq}, 3'b000);
        // Stale completion would end the wait below before the frame
        apb(1, OFF_STATUS, 32'h40);
        sendByte;
        apb(1, OFF_CONTROL, 32'h00); chk(sOutEn, 1'b1);
        waitSts(STS_TX_COMPLETE);
        repeat (3) @(posedge clk_sys);
        chk({sOutEn, sckEn, sentQ.size() == 0}, 3'b001);
        finish_test;
    end
endmodule
